// File: src/memory_error_manager.sv
// memory ecc error collector with reporting table and fault reports
//
// Overview of operation
// - accept ecc events from three memories
// - record failing address of each event not yet in the table, while a free entry remains
// - keep correctable/uncorrectable class with entry
// - report new correctables, every uncorrectable unless overwritten in pend_q
// - table readable through software read port
// - software-known addresses suppress correctable reports
// - eeprom flash events delivered like others
// - eeprom single-bit: corrected data, correctable event
// - eeprom multi-bit: illegal word, uncorrectable event
`timescale 1ns/10ps
`default_nettype none
module memory_error_manager
  import mem_err_pkg::*;
#(
  parameter int unsigned DEPTH = TABLE_DEPTH
) (
  // clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  // ecc checker events, one lane per memory
  input  wire logic [NUM_SRC-1:0]    ev_valid_in,
  input  wire logic [NUM_SRC-1:0]    ev_uncor_in,
  input  wire logic [NUM_SRC*ADDR_W-1:0] ev_addr_in,
  // eeprom flash read path
  input  wire logic                  ee_rd_valid_in,
  input  wire logic [DATA_W-1:0]     ee_rd_cor_data_in,
  input  wire logic                  ee_rd_single_in,
  input  wire logic                  ee_rd_multi_in,
  input  wire logic [ADDR_W-1:0]     ee_rd_addr_in,
  output logic                       ee_data_valid_out,
  output logic [DATA_W-1:0]          ee_data_out,
  // software table access (no bus: plain ports)
  input  wire logic                  sw_wr_in,
  input  wire logic [$clog2(DEPTH)-1:0] sw_idx_in,
  input  wire logic [ADDR_W-1:0]     sw_addr_in,
  output logic [ADDR_W-1:0]          sw_rd_addr_out,
  output logic                       sw_rd_class_out,
  output logic                       sw_rd_valid_out,
  input  wire logic                  sw_ovf_clr_in,
  output logic                       overflow_out,
  // reports to the fault_collection_unit
  output logic                       fault_collection_unit_cor_out,
  output logic                       fault_collection_unit_uncor_out,
  output logic [ADDR_W-1:0]          report_addr_out,
  output logic [SRC_W-1:0]           report_src_out
);
  localparam int unsigned IDX_W = $clog2(DEPTH);
  localparam int unsigned LANES = NUM_SRC + 1;      // eeprom path adds a lane

  // lane views
  logic [LANES-1:0]        lane_v;                  // event present
  logic [LANES-1:0]        lane_u;                  // uncorrectable
  logic [ADDR_W-1:0]       lane_a [LANES];          // address
  logic [SRC_W-1:0]        lane_s [LANES];          // reported source

  for (genvar l = 0; l < NUM_SRC; l++) begin : g_lane
    assign lane_v[l] = ev_valid_in[l];
    assign lane_u[l] = ev_uncor_in[l];
    assign lane_a[l] = ev_addr_in[l*ADDR_W +: ADDR_W];
    assign lane_s[l] = SRC_W'(l);
  end
  // eeprom events enter as an extra flash lane
  assign lane_v[NUM_SRC] = ee_rd_valid_in & (ee_rd_single_in | ee_rd_multi_in);
  assign lane_u[NUM_SRC] = ee_rd_multi_in;
  assign lane_a[NUM_SRC] = ee_rd_addr_in;
  assign lane_s[NUM_SRC] = SRC_FLASH;

  // fixed priority pick; lowest lane wins, others are held in pend_q and retry next cycle
  // limitation: simultaneous pulses on other lanes are serviced one per cycle via pend_q
  logic [LANES-1:0] pend_q;                          // events waiting
  logic [LANES-1:0] pend_u_q;                        // their class
  logic [ADDR_W-1:0] pend_a_q [LANES];               // their address
  logic [LANES-1:0] req_v;                           // pending or arriving
  logic [LANES-1:0] grant;                           // one-hot pick

  assign req_v = pend_q | lane_v;

  function automatic logic [LANES-1:0] pick_first(input logic [LANES-1:0] r);
    logic [LANES-1:0] g;
    g = '0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (r[i]) g = '0;
      if (r[i]) g[i] = 1'b1;
    end
    return g;
  endfunction
  assign grant = pick_first(req_v);

  // selected event: pending copy beats a fresh one on the same lane
  logic [ADDR_W-1:0] sel_a;
  logic              sel_u;
  logic [SRC_W-1:0]  sel_s;
  logic              sel_v;
  always_comb begin
    sel_a = '0;
    sel_u = 1'b0;
    sel_s = '0;
    for (int i = 0; i < LANES; i++) begin
      if (grant[i]) begin
        sel_a = pend_q[i] ? pend_a_q[i] : lane_a[i];
        sel_u = pend_q[i] ? pend_u_q[i] : lane_u[i];
        sel_s = lane_s[i];
      end
    end
  end
  assign sel_v = |grant;

  // hold events not granted; a new pulse on a waiting lane overwrites it
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pend_q   <= '0;
      pend_u_q <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (grant[i] && pend_q[i] && lane_v[i]) begin
          pend_q[i]   <= 1'b1;
          pend_u_q[i] <= lane_u[i];
        end else if (grant[i]) begin
          pend_q[i]   <= 1'b0;
        end else if (lane_v[i]) begin
          pend_q[i]   <= 1'b1;
          pend_u_q[i] <= lane_u[i];
        end
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_v[i] && (!grant[i] || pend_q[i])) pend_a_q[i] <= lane_a[i];
    end
  end

  // table lookup across all entries
  logic [DEPTH*ADDR_W-1:0] tbl_addr;
  logic [DEPTH-1:0]        tbl_valid;
  logic [DEPTH-1:0]        hit_vec;
  logic                    known;                    // address already in table
  for (genvar e = 0; e < DEPTH; e++) begin : g_cmp
    assign hit_vec[e] = tbl_valid[e] & (tbl_addr[e*ADDR_W +: ADDR_W] == sel_a);
  end
  assign known = |hit_vec;

  // free slot search
  logic [IDX_W-1:0] free_idx;
  logic             table_full;
  always_comb begin
    free_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!tbl_valid[i]) free_idx = IDX_W'(i);
    end
  end
  assign table_full = &tbl_valid;

  // decisions for the picked event
  wire report_cor   = sel_v & ~sel_u & ~known;
  wire report_uncor = sel_v & sel_u;
  wire hw_store     = sel_v & ~known & ~table_full;
  wire ovf_event    = sel_v & ~known & table_full;

  // software write has priority on the table port; hardware store is dropped
  // trade-off: a colliding hw store is dropped from the table, report still goes out
  wire              tbl_wr    = sw_wr_in | hw_store;
  wire [IDX_W-1:0]  tbl_idx   = sw_wr_in ? sw_idx_in : free_idx;
  wire [ADDR_W-1:0] tbl_waddr = sw_wr_in ? sw_addr_in : sel_a;
  wire              tbl_class = sw_wr_in ? CLASS_COR : sel_u;

  err_table_mem #(
    .DEPTH (DEPTH),
    .IDX_W (IDX_W)
  ) u_table (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .wr_en_in      (tbl_wr),
    .wr_idx_in     (tbl_idx),
    .wr_addr_in    (tbl_waddr),
    .wr_class_in   (tbl_class),
    .rd_idx_in     (sw_idx_in),
    .rd_addr_out   (sw_rd_addr_out),
    .rd_class_out  (sw_rd_class_out),
    .rd_valid_out  (sw_rd_valid_out),
    .all_addr_out  (tbl_addr),
    .all_valid_out (tbl_valid)
  );

  // overflow flag: set wins over clear
  logic ovf_q;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ovf_q <= 1'b0;
    end else if (ovf_event) begin
      ovf_q <= 1'b1;
    end else if (sw_ovf_clr_in) begin
      ovf_q <= 1'b0;
    end
  end
  assign overflow_out = ovf_q;

  // registered reports to the fault collector
  logic              rep_cor_q;
  logic              rep_unc_q;
  logic [ADDR_W-1:0] rep_addr_q;
  logic [SRC_W-1:0]  rep_src_q;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rep_cor_q  <= 1'b0;
      rep_unc_q  <= 1'b0;
      rep_addr_q <= '0;
      rep_src_q  <= '0;
    end else begin
      rep_cor_q <= report_cor;
      rep_unc_q <= report_uncor;
      if (report_cor || report_uncor) begin
        rep_addr_q <= sel_a;
        rep_src_q  <= sel_s;
      end
    end
  end
  assign fault_collection_unit_cor_out   = rep_cor_q;
  assign fault_collection_unit_uncor_out = rep_unc_q;
  assign report_addr_out                 = rep_addr_q;
  assign report_src_out                  = rep_src_q;

  // eeprom read data: corrected word or illegal-instruction fill
  logic              ee_v_q;
  logic [DATA_W-1:0] ee_d_q;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ee_v_q <= 1'b0;
      ee_d_q <= '0;
    end else begin
      ee_v_q <= ee_rd_valid_in;
      if (ee_rd_valid_in) begin
        ee_d_q <= ee_rd_multi_in ? ILLEGAL_WORD : ee_rd_cor_data_in;
      end
    end
  end
  assign ee_data_valid_out = ee_v_q;
  assign ee_data_out       = ee_d_q;
endmodule
`default_nettype wire

// File: src/mem_err_pkg.sv
// shared constants for the memory error manager
`default_nettype none
package mem_err_pkg;
  localparam int unsigned ADDR_W      = 29;         // failing address width
  localparam int unsigned NUM_SRC     = 3;          // sram, peripheral ram, flash
  localparam int unsigned SRC_W       = 2;          // source index width
  localparam int unsigned TABLE_DEPTH = 8;          // entries per reporting table
  localparam int unsigned DATA_W      = 64;         // flash read data width
  localparam logic [DATA_W-1:0] ILLEGAL_WORD = 64'h0000_0000_0000_0000; // illegal opcode fill
  localparam logic [SRC_W-1:0] SRC_SRAM  = 2'h0;
  localparam logic [SRC_W-1:0] SRC_PRAM  = 2'h1;
  localparam logic [SRC_W-1:0] SRC_FLASH = 2'h2;
  localparam logic              CLASS_COR   = 1'b0; // correctable
  localparam logic              CLASS_UNCOR = 1'b1; // uncorrectable
endpackage
`default_nettype wire

// File: src/err_table_mem.sv
// one reporting table: address/valid entries with registered read port
`timescale 1ns/10ps
`default_nettype none
module err_table_mem
  import mem_err_pkg::*;
#(
  parameter int unsigned DEPTH = TABLE_DEPTH,
  parameter int unsigned IDX_W = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  // write port
  input  wire logic             wr_en_in,
  input  wire logic [IDX_W-1:0] wr_idx_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic             wr_class_in,
  // registered read port
  input  wire logic [IDX_W-1:0] rd_idx_in,
  output logic [ADDR_W-1:0]     rd_addr_out,
  output logic                  rd_class_out,
  output logic                  rd_valid_out,
  // flat view for lookup
  output logic [DEPTH*ADDR_W-1:0] all_addr_out,
  output logic [DEPTH-1:0]      all_valid_out
);
  logic [ADDR_W-1:0] addr_q  [DEPTH];  // stored addresses
  logic [DEPTH-1:0]  valid_q;           // entry in use
  logic [DEPTH-1:0]  class_q;           // stored class

  // storage, valid cleared by reset only
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      valid_q <= '0;
    end else if (wr_en_in) begin
      valid_q[wr_idx_in] <= 1'b1;
    end
    if (wr_en_in) begin
      addr_q[wr_idx_in]  <= wr_addr_in;
      class_q[wr_idx_in] <= wr_class_in;
    end
  end

  // read data out of a register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_addr_out  <= '0;
      rd_class_out <= 1'b0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_addr_out  <= addr_q[rd_idx_in];
      rd_class_out <= class_q[rd_idx_in];
      rd_valid_out <= valid_q[rd_idx_in];
    end
  end

  // flatten for the parallel compare
  for (genvar i = 0; i < DEPTH; i++) begin : g_flat
    assign all_addr_out[i*ADDR_W +: ADDR_W] = addr_q[i];
  end
  assign all_valid_out = valid_q;
endmodule
`default_nettype wire

// File: verif/mem_err_monitor.sv
// concurrent checks on the memory error manager ports
`timescale 1ns/10ps
`default_nettype none
module mem_err_monitor
  import mem_err_pkg::*;
(
  // clock and reset
  input wire logic                      ref_clk_in,
  input wire logic                      rst_in,
  // event lanes and eeprom beat
  input wire logic [NUM_SRC-1:0]        ev_valid_in,
  input wire logic [NUM_SRC-1:0]        ev_uncor_in,
  input wire logic [NUM_SRC*ADDR_W-1:0] ev_addr_in,
  input wire logic                      ee_rd_valid_in,
  input wire logic                      ee_rd_multi_in,
  input wire logic [DATA_W-1:0]         ee_rd_cor_data_in,
  // results
  input wire logic                      ee_data_valid_out,
  input wire logic [DATA_W-1:0]         ee_data_out,
  input wire logic                      fault_collection_unit_cor_out,
  input wire logic                      fault_collection_unit_uncor_out,
  input wire logic [ADDR_W-1:0]         report_addr_out,
  input wire logic [SRC_W-1:0]          report_src_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // lane 0 never loses arbitration, so its answer is always next cycle
  wire logic lane0_unc = ev_valid_in[0] & ev_uncor_in[0];
  wire logic any_rep   = fault_collection_unit_cor_out | fault_collection_unit_uncor_out;
  a_unc_report_next: assert property (lane0_unc |=> fault_collection_unit_uncor_out)
    else $error("uncorrectable report missing");
  a_unc_addr_kept: assert property (lane0_unc |=> report_addr_out == $past(ev_addr_in[ADDR_W-1:0]))
    else $error("report address wrong");
  a_unc_src_lane: assert property (lane0_unc |=> report_src_out == SRC_SRAM)
    else $error("report source wrong");
  a_class_exclusive: assert property (!(fault_collection_unit_cor_out && fault_collection_unit_uncor_out))
    else $error("both classes reported");
  a_addr_moves_report: assert property (!$stable(report_addr_out) |-> any_rep)
    else $error("report address moved without report");
  a_ee_beat_answer: assert property (ee_rd_valid_in |=> ee_data_valid_out)
    else $error("eeprom data valid missing");
  a_ee_no_beat: assert property (!ee_rd_valid_in |=> !ee_data_valid_out)
    else $error("spurious eeprom data valid");
  a_ee_illegal_fill: assert property (ee_rd_valid_in && ee_rd_multi_in |=> ee_data_out == ILLEGAL_WORD)
    else $error("multi-bit data not replaced");
  a_ee_corrected: assert property (ee_rd_valid_in && !ee_rd_multi_in |=> ee_data_out == $past(ee_rd_cor_data_in))
    else $error("corrected data not returned");
endmodule
bind memory_error_manager mem_err_monitor mon (.ref_clk_in, .rst_in, .ev_valid_in, .ev_uncor_in, .ev_addr_in,
  .ee_rd_valid_in, .ee_rd_multi_in, .ee_rd_cor_data_in, .ee_data_valid_out, .ee_data_out,
  .fault_collection_unit_cor_out, .fault_collection_unit_uncor_out, .report_addr_out, .report_src_out);
`default_nettype wire

// File: verif/ecc_flash_model.sv
// flash read path stand-in that issues eeprom beats
`timescale 1ns/10ps
`default_nettype none
module ecc_flash_model
  import mem_err_pkg::*;
(
  // clock and bench request
  input  wire logic              ref_clk_in,
  input  wire logic              go_in,
  input  wire logic              multi_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  // read path toward the manager
  output logic                   ee_valid_out = 1'b0,
  output logic                   ee_single_out = 1'b0,
  output logic                   ee_multi_out = 1'b0,
  output logic [DATA_W-1:0]      ee_data_out = '0,
  output logic [ADDR_W-1:0]      ee_addr_out = '0
);
  // one beat a request; idle buses flip so stale data never looks good
  always @(posedge ref_clk_in) begin
    ee_valid_out  <= go_in;
    ee_single_out <= go_in & ~multi_in;
    ee_multi_out  <= go_in & multi_in;
    ee_data_out   <= go_in ? data_in : ~ee_data_out;
    ee_addr_out   <= go_in ? addr_in : ~ee_addr_out;
  end
endmodule
`default_nettype wire

// File: verif/memory_error_manager_tb_top.sv
// self-checking bench for the memory error manager
`timescale 1ns/10ps
`default_nettype none
module memory_error_manager_tb_top;
  import mem_err_pkg::*;
  // stimulus
  logic                      ref_clk_in = 1'b0;
  logic                      rst_in = 1'b1;
  logic [NUM_SRC-1:0]        ev_valid_in = '0, ev_uncor_in = '0;
  logic [NUM_SRC*ADDR_W-1:0] ev_addr_in = '0;
  logic                      go = 1'b0, multi = 1'b0, sw_wr_in = 1'b0, sw_ovf_clr_in = 1'b0;
  logic [DATA_W-1:0]         gdata = '0;
  logic [ADDR_W-1:0]         gaddr = '0, sw_addr_in = '0;
  logic [2:0]                sw_idx_in = '0;
  // design outputs and partner beat
  wire logic                 ee_v, ee_s, ee_m, ee_data_valid_out, sw_rd_class_out, sw_rd_valid_out, overflow_out;
  wire logic                 fault_collection_unit_cor_out, fault_collection_unit_uncor_out;
  wire logic [DATA_W-1:0]    ee_d, ee_data_out;
  wire logic [ADDR_W-1:0]    ee_a, sw_rd_addr_out, report_addr_out;
  wire logic [SRC_W-1:0]     report_src_out;
  // reference model state
  logic [ADDR_W-1:0]         tbl[$];
  bit                        cls[$];
  bit                        ovf;
  int                        errors, num_checks;
  logic [15:0]               rnd = 16'hA093;
  always #12.5 ref_clk_in = ~ref_clk_in;
  ecc_flash_model fm (.ref_clk_in, .go_in(go), .multi_in(multi), .data_in(gdata), .addr_in(gaddr),
    .ee_valid_out(ee_v), .ee_single_out(ee_s), .ee_multi_out(ee_m), .ee_data_out(ee_d), .ee_addr_out(ee_a));
  memory_error_manager dut (.ref_clk_in, .rst_in, .ev_valid_in, .ev_uncor_in, .ev_addr_in, .ee_rd_valid_in(ee_v),
    .ee_rd_cor_data_in(ee_d), .ee_rd_single_in(ee_s), .ee_rd_multi_in(ee_m), .ee_rd_addr_in(ee_a),
    .ee_data_valid_out, .ee_data_out, .sw_wr_in, .sw_idx_in, .sw_addr_in, .sw_rd_addr_out, .sw_rd_class_out,
    .sw_rd_valid_out, .sw_ovf_clr_in, .overflow_out, .fault_collection_unit_cor_out,
    .fault_collection_unit_uncor_out, .report_addr_out, .report_src_out);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // expected reaction: uncorrectables always, correctables only when new
  // every unknown address is stored while room is left, whatever its class
  task automatic model(input bit u, input logic [ADDR_W-1:0] a, output bit ec, output bit eu);
    bit kn;
    kn = (a inside {tbl});
    eu = u;
    ec = !u && !kn;
    if (!kn && tbl.size() < TABLE_DEPTH) begin
      tbl.push_back(a);
      cls.push_back(u);
    end else if (!kn) begin
      ovf = 1'b1;
    end
  endtask
  task automatic expect_rep(input bit ec, input bit eu, input logic [ADDR_W-1:0] a, input logic [1:0] s);
    chk(fault_collection_unit_cor_out, ec);
    chk(fault_collection_unit_uncor_out, eu);
    if (ec | eu) begin
      chk(report_addr_out, a);
      chk(report_src_out, s);
    end
  endtask
  task automatic ev(input int l, input bit u, input logic [ADDR_W-1:0] a);
    bit ec, eu;
    model(u, a, ec, eu);
    @(posedge ref_clk_in);
    ev_valid_in[l] <= 1'b1;
    ev_uncor_in[l] <= u;
    ev_addr_in[l*ADDR_W+:ADDR_W] <= a;
    @(posedge ref_clk_in);
    ev_valid_in[l] <= 1'b0;
    #1 expect_rep(ec, eu, a, l[1:0]);
  endtask
  // two uncorrectables in one cycle: lower lane first, the other one edge later
  task automatic ev_pair(input logic [ADDR_W-1:0] a1, input logic [ADDR_W-1:0] a2);
    @(posedge ref_clk_in);
    {ev_valid_in[2:1], ev_uncor_in[2:1]} <= 4'hF;
    ev_addr_in[ADDR_W+:2*ADDR_W] <= {a2, a1};
    @(posedge ref_clk_in);
    ev_valid_in[2:1] <= 2'h0;
    #1 expect_rep(1'b0, 1'b1, a1, SRC_PRAM);
    @(posedge ref_clk_in);
    #1 expect_rep(1'b0, 1'b1, a2, SRC_FLASH);
  endtask
  // eeprom beat via the partner; answer lands two edges after request
  task automatic ee(input bit m, input logic [ADDR_W-1:0] a);
    bit ec, eu;
    model(m, a, ec, eu);
    rnd = lfsr(rnd);
    @(posedge ref_clk_in);
    {go, multi, gaddr, gdata} <= {1'b1, m, a, {4{rnd}}};
    @(posedge ref_clk_in);
    go <= 1'b0;
    @(posedge ref_clk_in);
    #1 chk(ee_data_valid_out, 1'b1);
    chk(ee_data_out, m ? ILLEGAL_WORD : {4{rnd}});
    expect_rep(ec, eu, a, SRC_FLASH);
  endtask
  task automatic rd(input int i);
    @(posedge ref_clk_in);
    sw_idx_in <= i[2:0];
    @(posedge ref_clk_in);
    #1 chk({sw_rd_valid_out, sw_rd_class_out, sw_rd_addr_out}, {1'b1, cls[i], tbl[i]});
  endtask
  task automatic pulse_sw(input bit wr, input int i, input logic [ADDR_W-1:0] a);
    @(posedge ref_clk_in);
    {sw_wr_in, sw_ovf_clr_in, sw_idx_in, sw_addr_in} <= {wr, !wr, i[2:0], a};
    @(posedge ref_clk_in);
    {sw_wr_in, sw_ovf_clr_in} <= 2'h0;
    if (wr) begin
      tbl[i] = a;
      cls[i] = CLASS_COR;
    end else begin
      ovf = 1'b0;
    end
    repeat (2) @(posedge ref_clk_in);
    #1 chk(overflow_out, ovf);
  endtask
  task automatic complete_run;
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog far beyond the roughly 90 cycles the sequence needs
  initial begin
    #50000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1 chk({overflow_out, fault_collection_unit_cor_out}, 2'h0);
    // fill the table across the three event lanes, then read it back
    for (int i = 0; i < TABLE_DEPTH; i++) begin
      rnd = lfsr(rnd);
      ev(i % 3, 1'b0, {i[12:0], rnd});
    end
    for (int i = 0; i < TABLE_DEPTH; i++) rd(i);
    ev(0, 1'b0, tbl[0]);
    rnd = lfsr(rnd);
    ev(1, 1'b0, {13'h1FFF, rnd});
    repeat (2) @(posedge ref_clk_in);
    #1 chk(overflow_out, ovf);
    pulse_sw(1'b0, 0, '0);
    rnd = lfsr(rnd);
    pulse_sw(1'b1, 3, {13'h1ABC, rnd});
    ev(2, 1'b0, tbl[3]);
    rd(3);
    repeat (2) ev(0, 1'b1, tbl[0]);
    // unknown uncorrectable into a full table: reported and overflow raised
    ev(2, 1'b1, {13'h1555, rnd});
    chk(overflow_out, ovf);
    ev_pair(tbl[4], tbl[5]);
    ee(1'b0, {13'h0F0F, rnd});
    ee(1'b1, tbl[1]);
    repeat (2) @(posedge ref_clk_in);
    #1 chk(overflow_out, ovf);
    complete_run();
  end
endmodule
`default_nettype wire
